// ### rtl/sbl_loader.sv
/*
  tile boot loader: security word fetch, boot source choice, image parse with
  crc-32 check, ram copy and start, security gating of jtag, link, otp
  programming and the debug sync pin, plus a byte fifo in the image path.
  assumes an otp array answering reads with a valid pulse, a quad flash that
  presents one nibble per rising edge of its own clock and honours hold,
  and an outside pull-down cell driven by gpio_pulldown_ff.
*/
`timescale 1ns/1ps
`include "sbl_params.svh"

// byte fifo: flip-flop storage, full and empty straight from the fill level
module sbl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH]; // storage
  logic [AW-1:0] wr_ff; // write index
  logic [AW-1:0] rd_ff; // read index
  logic [AW:0] cnt_ff; // fill level
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_ff != (AW+1)'(DEPTH)); // full only at DEPTH, needs the extra bit
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ff];
  // pointers and level
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
      if (pop) rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // data store, no reset needed
  always_ff @(posedge clk) begin
    if (push) mem_ff[wr_ff] <= in_data;
  end
endmodule

module sbl_loader #(
  parameter int RAM_AW = 18, // byte address width of tile ram
  parameter int FIFO_DEPTH = 8, // image byte buffer depth
  parameter logic [31:0] ID_WORD = 32'h0000_0abd, // arbitrary identity value
  parameter logic [21:0] REV_FIELD = 22'h00_0001 // arbitrary revision value
) (
  input wire logic clk,
  input wire logic rst,
  output logic gpio_pulldown_ff,
  output sbl_pkg::sbl_state_t state_ff,
  output logic cpu_start_ff,
  output logic ram_we_ff,
  output logic [RAM_AW-1:0] ram_addr_ff,
  output logic [7:0] ram_wdata_ff,
  output logic otp_rd_en_ff,
  output logic otp_rd_sec_ff,
  output logic [`SBL_OTP_ROW_W-1:0] otp_rd_addr_ff,
  input wire logic otp_rd_valid,
  input wire logic [31:0] otp_rd_data,
  output logic flash_req_ff,
  output logic flash_hold_ff,
  input wire logic flash_clk,
  input wire logic [3:0] flash_dq,
  input wire logic pgm_we,
  input wire logic [23:0] pgm_port_id,
  input wire logic [31:0] pgm_wdata,
  output logic otp_wr_en_ff,
  output logic otp_wr_sec_ff,
  output logic [`SBL_OTP_ROW_W-1:0] otp_wr_addr_ff,
  output logic [31:0] otp_wr_data_ff,
  output logic otp_pgm_err_ff,
  output logic otp_redund_ff,
  output logic jtag_block_ff,
  output logic link_block_ff,
  input wire logic [3:0] jtag_ir,
  output logic [31:0] jtag_dr_ff,
  input wire logic debug_out_mode,
  input wire logic breakpoint,
  input wire logic debug_in,
  output logic debug_out,
  output logic debug_oe_ff,
  output logic debug_req_ff
);
  import sbl_pkg::*;

  localparam logic [11:0] WAIT_CYC = 12'(`SBL_BOOT_WAIT_CYC);

  logic [31:0] sec_ff; // security word, loaded once after reset
  logic [11:0] wait_cnt_ff; // internal reset delay
  logic boot_otp_ff; // image comes from otp
  logic [31:0] acc_ff; // lsb-first word assembly
  logic [1:0] bidx_ff; // byte index within a word
  logic [31:0] words_ff; // program words still to copy
  logic [31:0] crc_ff; // running crc residue
  logic [31:0] fword_ff; // otp word being split into bytes
  logic [2:0] fbytes_ff; // bytes of fword_ff still to push
  logic [7:0] fbyte_ff; // flash byte waiting for the fifo
  logic fbyte_v_ff; // fbyte_ff holds a byte
  logic [3:0] flo_ff; // low nibble of flash byte
  logic fhalf_ff; // low nibble captured
  logic [2:0] fclk_s_ff; // flash clock synchroniser
  logic [3:0] fdq_s1_ff, fdq_s2_ff, fdq_s3_ff; // flash data synchroniser
  logic fclk_lvl_ff; // agreed flash clock level
  logic [2:0] dbg_s_ff; // debug input synchroniser
  logic [31:0] pa_ff, pd_ff, pc_ff; // programming port latches
  logic rd_wait_ff; // an otp read is in flight, only one at a time
  sbl_state_t nxt_state;

  // crc over one byte, reflected, lsb of data first
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r >> 1) ^ (`SBL_CRC_POLY & {32{r[0] ^ d[i]}});
    end
    return r;
  endfunction

  // fifo hookup: source is the otp splitter or the flash assembler
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire loading = (state_ff == SBL_SIZE) || (state_ff == SBL_PROG) || (state_ff == SBL_CHECK);
  wire src_valid = boot_otp_ff ? (fbytes_ff != 3'h0) : fbyte_v_ff;
  wire [7:0] src_data = boot_otp_ff ? fword_ff[7:0] : fbyte_ff;
  wire push_ok = src_valid && fifo_in_ready && loading;
  wire take = fifo_out_valid && loading; // parser never stalls
  wire word_done = take && (bidx_ff == 2'h3);
  wire [31:0] word_now = {fifo_out_data, acc_ff[31:8]};
  wire [31:0] crc_now = crc_byte(crc_ff, fifo_out_data);
  wire crc_ok = (word_now == `SBL_MAGIC_NOCHECK) || (word_now == ~crc_ff);

  sbl_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(src_valid && loading),
    .in_ready(fifo_in_ready),
    .in_data(src_data),
    .out_valid(fifo_out_valid),
    .out_ready(loading),
    .out_data(fifo_out_data)
  );

  // next state of the loader
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SBL_WAIT: if (wait_cnt_ff == WAIT_CYC - 12'h001) nxt_state = SBL_SEC;
      SBL_SEC: if (otp_rd_valid) nxt_state = SBL_SIZE;
      SBL_SIZE: if (word_done) nxt_state = (word_now == '0) ? SBL_CHECK : SBL_PROG;
      SBL_PROG: if (take && bidx_ff == 2'h3 && words_ff == 32'h1) nxt_state = SBL_CHECK;
      SBL_CHECK: if (word_done) nxt_state = crc_ok ? SBL_RUN : SBL_FAIL;
      SBL_RUN: nxt_state = SBL_RUN;
      SBL_FAIL: nxt_state = SBL_FAIL; // bad image parks the tile
      default: nxt_state = SBL_FAIL;
    endcase
  end

  // sequence, delay and pull-down
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= SBL_WAIT;
      wait_cnt_ff <= '0;
      gpio_pulldown_ff <= 1'b1;
      cpu_start_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == SBL_WAIT) wait_cnt_ff <= wait_cnt_ff + 12'h001;
      gpio_pulldown_ff <= 1'b0; // pins belong to software after release
      cpu_start_ff <= (nxt_state == SBL_RUN);
    end
  end

  // security word fetch; later words only feed the image path
  always_ff @(posedge clk) begin
    if (rst) begin
      sec_ff <= '0;
      boot_otp_ff <= 1'b0;
      otp_rd_sec_ff <= 1'b0;
    end else if (state_ff == SBL_SEC && otp_rd_valid) begin
      sec_ff <= otp_rd_data;
      boot_otp_ff <= otp_rd_data[`SBL_SEC_OTP_BOOT];
      otp_rd_sec_ff <= 1'b0;
    end else begin
      otp_rd_sec_ff <= (state_ff == SBL_SEC);
    end
  end

  // next otp read: security word, or a new image row once the last one is split
  // a second read in flight would replay a row or feed the security word as image
  wire rd_issue = !otp_rd_en_ff && !rd_wait_ff
    && ((state_ff == SBL_SEC) || (loading && boot_otp_ff && fbytes_ff == 3'h0));

  // otp image reader: rows from address zero, split lsb first
  always_ff @(posedge clk) begin
    if (rst) begin
      otp_rd_en_ff <= 1'b0;
      rd_wait_ff <= 1'b0;
      otp_rd_addr_ff <= '0;
      fword_ff <= '0;
      fbytes_ff <= '0;
    end else begin
      otp_rd_en_ff <= rd_issue;
      if (otp_rd_en_ff) rd_wait_ff <= 1'b1; // request taken
      else if (otp_rd_valid) rd_wait_ff <= 1'b0; // answer back
      if (state_ff != SBL_SEC && otp_rd_valid && boot_otp_ff) begin
        fword_ff <= otp_rd_data;
        fbytes_ff <= 3'h4;
        otp_rd_addr_ff <= otp_rd_addr_ff + 1'b1; // wraps after 2048 rows
      end else if (push_ok && boot_otp_ff) begin
        fword_ff <= {8'h00, fword_ff[31:8]};
        fbytes_ff <= fbytes_ff - 3'h1;
      end
    end
  end

  // flash link synchronisers, three stages each
  always_ff @(posedge clk) begin
    if (rst) begin
      fclk_s_ff <= '0;
      fdq_s1_ff <= '0;
      fdq_s2_ff <= '0;
      fdq_s3_ff <= '0;
      dbg_s_ff <= 3'h7;
    end else begin
      fclk_s_ff <= {fclk_s_ff[1:0], flash_clk};
      fdq_s1_ff <= flash_dq;
      fdq_s2_ff <= fdq_s1_ff;
      fdq_s3_ff <= fdq_s2_ff;
      dbg_s_ff <= {dbg_s_ff[1:0], debug_in};
    end
  end

  // flash edge: agreed level goes low to high
  wire fclk_agree = (fclk_s_ff[1] == fclk_s_ff[2]);
  wire fclk_rise = fclk_agree && fclk_s_ff[2] && !fclk_lvl_ff;

  // flash byte assembly, low nibble first; hold stalls the flash
  always_ff @(posedge clk) begin
    if (rst) begin
      fclk_lvl_ff <= 1'b0;
      fhalf_ff <= 1'b0;
      flo_ff <= '0;
      fbyte_ff <= '0;
      fbyte_v_ff <= 1'b0;
      flash_req_ff <= 1'b0;
      flash_hold_ff <= 1'b0;
    end else begin
      if (fclk_agree) fclk_lvl_ff <= fclk_s_ff[2];
      flash_req_ff <= loading && !boot_otp_ff;
      flash_hold_ff <= fbyte_v_ff || !fifo_in_ready;
      if (push_ok && !boot_otp_ff) fbyte_v_ff <= 1'b0;
      if (fclk_rise && flash_req_ff) begin
        fhalf_ff <= !fhalf_ff;
        if (!fhalf_ff) begin
          flo_ff <= fdq_s3_ff;
        end else begin
          fbyte_ff <= {fdq_s3_ff, flo_ff};
          fbyte_v_ff <= 1'b1;
        end
      end
    end
  end

  // image parser, crc and ram copy
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_ff <= '0;
      bidx_ff <= '0;
      words_ff <= '0;
      crc_ff <= `SBL_CRC_PRESET;
      ram_we_ff <= 1'b0;
      ram_addr_ff <= '0;
      ram_wdata_ff <= '0;
    end else begin
      ram_we_ff <= take && (state_ff == SBL_PROG);
      if (ram_we_ff) ram_addr_ff <= ram_addr_ff + 1'b1;
      if (take) begin
        acc_ff <= word_now;
        bidx_ff <= bidx_ff + 2'h1;
        ram_wdata_ff <= fifo_out_data;
        if (state_ff != SBL_CHECK) crc_ff <= crc_now;
        if (state_ff == SBL_SIZE && bidx_ff == 2'h3) words_ff <= word_now;
        if (state_ff == SBL_PROG && bidx_ff == 2'h3) words_ff <= words_ff - 32'h1;
      end
    end
  end

  // security gates held as flops
  always_ff @(posedge clk) begin
    if (rst) begin
      jtag_block_ff <= 1'b0;
      link_block_ff <= 1'b0;
      otp_redund_ff <= 1'b0;
    end else begin
      jtag_block_ff <= sec_ff[`SBL_SEC_NO_JTAG];
      link_block_ff <= sec_ff[`SBL_SEC_NO_LINK];
      otp_redund_ff <= sec_ff[`SBL_SEC_REDUND];
    end
  end

  // programming ports: address, data, then control go
  wire pgm_go = pgm_we && (pgm_port_id == `SBL_PORT_OTP_CTRL) && pgm_wdata[`SBL_CTRL_GO];
  wire [1:0] pgm_sector = pa_ff[`SBL_OTP_SECTOR_HI:`SBL_OTP_SECTOR_LO];
  wire sect_lock = sec_ff[`SBL_SEC_LOCK_LO + 32'(pgm_sector)];
  wire pgm_to_sec = pgm_wdata[`SBL_CTRL_SEC];
  wire pgm_deny = sec_ff[`SBL_SEC_MASTER_LOCK]
    || (!pgm_to_sec && sect_lock)
    || (pgm_wdata[`SBL_CTRL_JTAG] && sec_ff[`SBL_SEC_NO_JTAG_OTP]);

  always_ff @(posedge clk) begin
    if (rst) begin
      pa_ff <= '0;
      pd_ff <= '0;
      pc_ff <= '0;
      otp_wr_en_ff <= 1'b0;
      otp_wr_sec_ff <= 1'b0;
      otp_wr_addr_ff <= '0;
      otp_wr_data_ff <= '0;
      otp_pgm_err_ff <= 1'b0;
    end else begin
      if (pgm_we && pgm_port_id == `SBL_PORT_OTP_ADDR) pa_ff <= {16'h0000, pgm_wdata[15:0]};
      if (pgm_we && pgm_port_id == `SBL_PORT_OTP_DATA) pd_ff <= pgm_wdata;
      if (pgm_we && pgm_port_id == `SBL_PORT_OTP_CTRL) pc_ff <= {16'h0000, pgm_wdata[15:0]};
      otp_wr_en_ff <= pgm_go && !pgm_deny;
      otp_pgm_err_ff <= pgm_go && pgm_deny;
      if (pgm_go) begin
        otp_wr_sec_ff <= pgm_to_sec;
        otp_wr_addr_ff <= pa_ff[`SBL_OTP_ROW_W-1:0];
        otp_wr_data_ff <= pd_ff;
      end
    end
  end

  // tap data register: 32 bits picked by the 4-bit instruction
  wire [31:0] user_word = {sec_ff[`SBL_SEC_UID_HI:`SBL_SEC_UID_LO], REV_FIELD};
  wire otp_peek_ok = !sec_ff[`SBL_SEC_NO_JTAG_OTP] && !sec_ff[`SBL_SEC_NO_JTAG];
  always_ff @(posedge clk) begin
    if (rst) begin
      jtag_dr_ff <= '0;
    end else begin
      unique case (jtag_ir)
        `SBL_IR_JTAG_IDENTITY_WORD: jtag_dr_ff <= ID_WORD;
        `SBL_IR_USERCODE: jtag_dr_ff <= user_word;
        `SBL_IR_OTP_READ: jtag_dr_ff <= otp_peek_ok ? pd_ff : '0;
        default: jtag_dr_ff <= '0;
      endcase
    end
  end

  // debug sync pin: open-drain low on break, low input requests debug
  assign debug_out = 1'b0; // only ever pulls low
  always_ff @(posedge clk) begin
    if (rst) begin
      debug_oe_ff <= 1'b0;
      debug_req_ff <= 1'b0;
    end else begin
      debug_oe_ff <= !sec_ff[`SBL_SEC_NO_DEBUG] && debug_out_mode && breakpoint;
      if (dbg_s_ff[1] == dbg_s_ff[2]) begin
        debug_req_ff <= !sec_ff[`SBL_SEC_NO_DEBUG] && !debug_out_mode && !dbg_s_ff[2];
      end
    end
  end

  // checks
  property p_pulldown;
    @(posedge clk) gpio_pulldown_ff |-> $past(rst);
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pull-down left on after reset");

  property p_boot_wait;
    @(posedge clk) disable iff (rst)
      (state_ff == SBL_WAIT) && $past(state_ff) == SBL_WAIT |-> wait_cnt_ff <= WAIT_CYC;
  endproperty
  a_boot_wait: assert property (p_boot_wait) else $error("boot delay overran");

  property p_sec_boot;
    @(posedge clk) disable iff (rst)
      (state_ff == SBL_SEC) && otp_rd_valid
        |=> boot_otp_ff == $past(otp_rd_data[`SBL_SEC_OTP_BOOT]);
  endproperty
  a_sec_boot: assert property (p_sec_boot) else $error("boot source not from bit 5");

  property p_magic;
    @(posedge clk) disable iff (rst)
      (state_ff == SBL_CHECK) && word_done && word_now == `SBL_MAGIC_NOCHECK
        |=> state_ff == SBL_RUN;
  endproperty
  a_magic: assert property (p_magic) else $error("magic word did not skip check");

  property p_bad_crc;
    @(posedge clk) disable iff (rst)
      (state_ff == SBL_CHECK) && word_done && !crc_ok |=> state_ff == SBL_FAIL ##1 !cpu_start_ff;
  endproperty
  a_bad_crc: assert property (p_bad_crc) else $error("bad image was started");

  property p_ram_zero;
    @(posedge clk) disable iff (rst)
      $rose(state_ff == SBL_PROG) |-> ram_addr_ff == '0 ##1 ram_addr_ff == '0;
  endproperty
  a_ram_zero: assert property (p_ram_zero) else $error("copy not from address zero");

  property p_master_lock;
    @(posedge clk) disable iff (rst)
      otp_wr_en_ff |-> !$past(sec_ff[`SBL_SEC_MASTER_LOCK])
        && !$past(sect_lock && !pgm_to_sec);
  endproperty
  a_master_lock: assert property (p_master_lock) else $error("locked otp was programmed");

  property p_debug_off;
    @(posedge clk) disable iff (rst) $past(sec_ff[`SBL_SEC_NO_DEBUG]) |-> !debug_oe_ff;
  endproperty
  a_debug_off: assert property (p_debug_off) else $error("debug pin driven while disabled");
endmodule

// ### rtl/sbl_params.svh
/*
  constants of the tile boot loader: timing, security word bits, image layout,
  otp geometry, programming port ids and tap instruction codes.
  assumes one 200 MHz clock feeding every process of the loader.
*/
`ifndef SBL_PARAMS_SVH
`define SBL_PARAMS_SVH
// clock and boot delay
`define SBL_CLK_PS 5000
`define SBL_BOOT_WAIT_NS 15000
`define SBL_BOOT_WAIT_CYC (((`SBL_BOOT_WAIT_NS * 1000) + `SBL_CLK_PS - 1) / `SBL_CLK_PS)
// security word bit positions
`define SBL_SEC_NO_JTAG 0
`define SBL_SEC_NO_LINK 1
`define SBL_SEC_OTP_BOOT 5
`define SBL_SEC_REDUND 7
`define SBL_SEC_LOCK_LO 8
`define SBL_SEC_MASTER_LOCK 12
`define SBL_SEC_NO_JTAG_OTP 13
`define SBL_SEC_NO_DEBUG 14
`define SBL_SEC_UID_LO 22
`define SBL_SEC_UID_HI 31
// image layout
`define SBL_MAGIC_NOCHECK 32'h0d15ab1e
`define SBL_CRC_POLY 32'hedb88320
`define SBL_CRC_PRESET 32'hffffffff
// otp geometry: four sectors of 512 rows
`define SBL_OTP_ROW_W 11
`define SBL_OTP_SECTOR_HI 10
`define SBL_OTP_SECTOR_LO 9
// programming port ids
`define SBL_PORT_OTP_ADDR 24'h100200
`define SBL_PORT_OTP_DATA 24'h200100
`define SBL_PORT_OTP_CTRL 24'h100300
// control port bits: go, target security word, from jtag
`define SBL_CTRL_GO 0
`define SBL_CTRL_SEC 1
`define SBL_CTRL_JTAG 2
// tap instructions
`define SBL_IR_JTAG_IDENTITY_WORD 4'h1
`define SBL_IR_USERCODE 4'h2
`define SBL_IR_OTP_READ 4'h3
`endif

// ### rtl/sbl_pkg.sv
/*
  types shared by the boot loader files.
  assumes sbl_params.svh is included where numbers are needed.
*/
package sbl_pkg;
  // loader sequence, one-hot
  typedef enum logic [6:0] {
    SBL_WAIT = 7'h01,
    SBL_SEC = 7'h02,
    SBL_SIZE = 7'h04,
    SBL_PROG = 7'h08,
    SBL_CHECK = 7'h10,
    SBL_RUN = 7'h20,
    SBL_FAIL = 7'h40
  } sbl_state_t;
endpackage

// ### test/sbl_far_model.sv
/*
  far-side model: otp array answering reads and a quad flash streaming a
  byte image on its own link clock.
  assumes the bench loads img, img_len and sec_word before reset ends.
*/
`timescale 1ns/1ps
module sbl_far_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic rd_en,
  input wire logic rd_sec,
  input wire logic [10:0] rd_addr,
  output logic rd_valid,
  output logic [31:0] rd_data,
  input wire logic req,
  input wire logic hold,
  output logic fclk,
  output logic [3:0] dq
);
  logic [7:0] img [0:63]; // image bytes, same layout in flash and otp
  logic [31:0] sec_word; // otp security word
  logic [1:0] dly; // read latency pipe
  logic [3:0] row; // latched row, image is only 16 words
  logic sel_sec; // latched security word target
  int img_len;
  int nib;
  initial begin
    fclk = 0;
    dq = 4'h0;
    nib = 0;
    dly = 2'h0;
    rd_valid = 0;
    rd_data = 32'h0;
  end
  // otp: answer three cycles late, data only in the valid cycle
  always @(posedge clk) begin
    dly <= {dly[0], rd_en && !rst};
    if (rd_en) row <= rd_addr[3:0];
    if (rd_en) sel_sec <= rd_sec;
    rd_valid <= dly[1];
    if (dly[1]) begin
      rd_data <= sel_sec ? sec_word : {img[4*row+3], img[4*row+2], img[4*row+1], img[4*row]};
    end else begin
      rd_data <= ~rd_data; // stale data never looks valid
    end
  end
  // flash: link clock stands still unless streaming; hold seen each period
  always begin
    #12;
    if (rst || !req) nib = 0; // a new request reads from the start, a short reset too
    if (!rst && req && !hold && nib < 2 * img_len) begin
      dq = nib[0] ? img[nib/2][7:4] : img[nib/2][3:0]; // low nibble first
      #12 fclk = 1;
      #24 fclk = 0;
      nib++;
    end else begin
      dq = ~dq; // released lines toggle
    end
  end
endmodule

// ### test/sbl_loader_tb.sv
/*
  bench of the boot loader: one row per boot, then a mid-image reset.
  assumes the far-side model and the loader with its package and constants.
*/
`timescale 1ns/1ps
`include "sbl_params.svh"
module sbl_loader_tb;
  import sbl_pkg::*;
  localparam logic [31:0] ID = 32'h0000_0c35; // arbitrary identity value
  localparam logic [21:0] REV = 22'h00_0007; // arbitrary revision value
  typedef struct packed {
    logic [31:0] sec;
    logic [3:0] size;
    logic [1:0] mode; // 0 good crc, 1 bad crc, 2 magic
    sbl_state_t fin;
  } sbl_row_t;
  logic clk, rst, gpio_pulldown_ff, cpu_start_ff, ram_we_ff, otp_rd_en_ff, otp_rd_sec_ff;
  logic otp_rd_valid, flash_req_ff, flash_hold_ff, flash_clk, pgm_we, otp_wr_en_ff;
  logic otp_wr_sec_ff, otp_pgm_err_ff, otp_redund_ff, jtag_block_ff, link_block_ff;
  logic debug_out_mode, breakpoint, debug_in, debug_out, debug_oe_ff, debug_req_ff, ext_low;
  logic [17:0] ram_addr_ff;
  logic [7:0] ram_wdata_ff;
  logic [10:0] otp_rd_addr_ff, otp_wr_addr_ff, first_row;
  logic [31:0] otp_rd_data, pgm_wdata, otp_wr_data_ff, jtag_dr_ff;
  logic [3:0] flash_dq, jtag_ir;
  logic [23:0] pgm_port_id;
  sbl_state_t state_ff;
  logic [7:0] ram [64]; // bytes the loader wrote
  logic flash_used, otp_used;
  int wr_cnt, miscompares, comparisons;
  sbl_row_t rows [7] = '{
    '{32'h0000_0000, 4'd2, 2'd0, SBL_RUN},
    '{32'h0000_0000, 4'd3, 2'd1, SBL_FAIL},
    '{32'h0000_0000, 4'd2, 2'd2, SBL_RUN},
    '{32'h0000_0020, 4'd3, 2'd0, SBL_RUN},
    '{32'hffc0_4283, 4'd0, 2'd2, SBL_RUN},
    '{32'h0000_3100, 4'd2, 2'd0, SBL_RUN},
    '{32'h0000_2120, 4'd1, 2'd1, SBL_FAIL}
  };
  sbl_loader #(.ID_WORD(ID), .REV_FIELD(REV)) DUT (
    .clk, .rst, .gpio_pulldown_ff, .state_ff, .cpu_start_ff, .ram_we_ff, .ram_addr_ff,
    .ram_wdata_ff, .otp_rd_en_ff, .otp_rd_sec_ff, .otp_rd_addr_ff, .otp_rd_valid,
    .otp_rd_data, .flash_req_ff, .flash_hold_ff, .flash_clk, .flash_dq, .pgm_we,
    .pgm_port_id, .pgm_wdata, .otp_wr_en_ff, .otp_wr_sec_ff, .otp_wr_addr_ff,
    .otp_wr_data_ff, .otp_pgm_err_ff, .otp_redund_ff, .jtag_block_ff, .link_block_ff,
    .jtag_ir, .jtag_dr_ff, .debug_out_mode, .breakpoint, .debug_in, .debug_out,
    .debug_oe_ff, .debug_req_ff
  );
  sbl_far_model far (
    .clk(clk), .rst(rst), .rd_en(otp_rd_en_ff), .rd_sec(otp_rd_sec_ff),
    .rd_addr(otp_rd_addr_ff), .rd_valid(otp_rd_valid), .rd_data(otp_rd_data),
    .req(flash_req_ff), .hold(flash_hold_ff), .fclk(flash_clk), .dq(flash_dq)
  );
  // debug pin: pull-up, low when the loader or the outside drives it
  assign debug_in = !(debug_oe_ff || ext_low);
  always #2.5 clk = ~clk;
  // monitor of ram writes and of which boot source was used
  always @(posedge clk) begin
    if (ram_we_ff) ram[ram_addr_ff[5:0]] <= ram_wdata_ff;
    if (ram_we_ff) wr_cnt <= wr_cnt + 1;
    if (flash_req_ff) flash_used <= 1;
    if (otp_rd_en_ff && !otp_rd_sec_ff && !otp_used) first_row <= otp_rd_addr_ff;
    if (otp_rd_en_ff && !otp_rd_sec_ff) otp_used <= 1;
  end
  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    comparisons++;
    if (e !== s) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // inputs always change 1 ns after a rising edge
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [31:0] crc(int n);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < n; i++) begin
      c = c ^ {24'h0, far.img[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    return ~c;
  endfunction
  // image: size word, program bytes, check word, all lsb first
  task automatic load(sbl_row_t r);
    logic [31:0] c;
    int n;
    n = 8 + 4 * r.size;
    for (int i = 0; i < 4; i++) far.img[i] = (i == 0) ? {4'h0, r.size} : 8'h00;
    for (int i = 4; i < n - 4; i++) far.img[i] = 8'(i * 37 + r.sec[5:0]);
    c = crc(n - 4);
    if (r.mode == 2'd1) c = c ^ 32'h1;
    if (r.mode == 2'd2) c = 32'h0d15ab1e;
    for (int i = 0; i < 4; i++) far.img[n-4+i] = c[8*i +: 8];
    far.img_len = n;
    far.sec_word = r.sec;
  endtask
  task automatic put(logic [23:0] id, logic [31:0] d);
    pgm_we = 1;
    pgm_port_id = id;
    pgm_wdata = d;
    cyc(1);
  endtask
  // one programming sequence; the answer is looked for in two cycles
  task automatic pgm(logic [15:0] a, logic [2:0] ctl, logic exp_err);
    logic w, e, ws;
    logic [10:0] wa;
    logic [31:0] wd;
    w = 0;
    e = 0;
    put(`SBL_PORT_OTP_ADDR, {16'h0, a});
    put(`SBL_PORT_OTP_DATA, {a, ~a});
    put(`SBL_PORT_OTP_CTRL, {29'h0, ctl});
    pgm_we = 0;
    for (int i = 0; i < 2; i++) begin
      if (otp_wr_en_ff === 1'b1) begin
        w = 1;
        wa = otp_wr_addr_ff;
        wd = otp_wr_data_ff;
        ws = otp_wr_sec_ff;
      end
      if (otp_pgm_err_ff === 1'b1) e = 1;
      cyc(1);
    end
    chk("otp write", {31'h0, !exp_err}, {31'h0, w});
    chk("otp refused", {31'h0, exp_err}, {31'h0, e});
    if (w) chk("otp row", {21'h0, a[10:0]}, {21'h0, wa});
    if (w) chk("otp data", {a, ~a}, wd);
    if (w) chk("otp target", {31'h0, ctl[1]}, {31'h0, ws});
  endtask
  task automatic boot(sbl_row_t r);
    logic [31:0] s;
    int k;
    s = r.sec;
    load(r);
    foreach (ram[i]) ram[i] = 'x;
    wr_cnt = 0;
    flash_used = 0;
    otp_used = 0;
    rst = 1; // held several cycles before release
    cyc(1);
    chk("pulldown in reset", 1, gpio_pulldown_ff);
    cyc(3);
    rst = 0;
    cyc(1);
    chk("pulldown after", 0, gpio_pulldown_ff);
    k = 1;
    while (state_ff === SBL_WAIT && k < 4000) begin
      cyc(1);
      k++;
    end
    chk("boot delay", 1, k >= 2999 && k <= 3001);
    k = 0;
    while (state_ff !== SBL_RUN && state_ff !== SBL_FAIL && k < 20000) begin
      cyc(1);
      k++;
    end
    if (k == 20000) miscompares++;
    if (k == 20000) results();
    chk("final state", r.fin, state_ff);
    chk("start", r.fin == SBL_RUN, cpu_start_ff);
    if (r.fin == SBL_RUN) chk("ram writes", 4 * r.size, wr_cnt);
    for (int i = 0; r.fin == SBL_RUN && i < 4 * r.size; i++) begin
      chk("ram byte", far.img[4+i], ram[i]);
    end
    chk("flash used", !s[5], flash_used);
    chk("otp used", s[5], otp_used);
    if (s[5]) chk("otp first row", 0, first_row);
    chk("jtag block", s[0], jtag_block_ff);
    chk("link block", s[1], link_block_ff);
    chk("redundant rows", s[7], otp_redund_ff);
    chk("hold idle", 0, flash_hold_ff);
    jtag_ir = `SBL_IR_JTAG_IDENTITY_WORD;
    cyc(2);
    chk("identity", ID, jtag_dr_ff);
    jtag_ir = `SBL_IR_USERCODE;
    cyc(2);
    chk("user word", {s[31:22], REV}, jtag_dr_ff);
    pgm(16'h0200, 3'b001, s[12] | s[9]);
    pgm(16'h0000, 3'b101, s[12] | s[8] | s[13]);
    pgm(16'h0600, 3'b011, s[12]);
    jtag_ir = `SBL_IR_OTP_READ;
    cyc(2);
    chk("otp over tap", (s[13] | s[0]) ? 32'h0 : 32'h0600_f9ff, jtag_dr_ff);
    debug_out_mode = 1;
    breakpoint = 1;
    cyc(2);
    chk("debug drive", !s[14], debug_oe_ff);
    chk("debug level", 0, debug_out);
    breakpoint = 0;
    debug_out_mode = 0;
    ext_low = 1;
    cyc(4);
    chk("debug tristate", 0, debug_oe_ff);
    chk("debug request", !s[14], debug_req_ff);
    ext_low = 0;
  endtask
  initial begin
    clk = 0;
    rst = 1;
    pgm_we = 0;
    pgm_port_id = 24'h0;
    pgm_wdata = 32'h0;
    jtag_ir = 4'h0;
    debug_out_mode = 0;
    breakpoint = 0;
    ext_low = 0;
    miscompares = 0;
    comparisons = 0;
    foreach (rows[i]) boot(rows[i]);
    // reset in the middle of an image stream, then a clean boot
    load(rows[0]);
    rst = 1;
    cyc(4);
    rst = 0;
    cyc(3300);
    boot(rows[0]);
    results();
  end
endmodule
